// *** hw/ecclog_err_if.sv ***
`timescale 1ns/10ps
interface ecclog_err_if;
  logic hit;
  logic dbl;
  logic single;
  logic [ecclog_pkg::SYN_W-1:0] syn;
  modport src(output hit, output dbl, output single, output syn);
  modport dst(input hit, input dbl, input single, input syn);
endinterface

// *** hw/ecclog_err_qual.sv ***
`timescale 1ns/10ps
module ecclog_err_qual (
  input wire logic clk,
  input wire logic resetn,
  input wire logic readCycle,
  input wire logic singleErr,
  input wire logic doubleErr,
  input wire logic [ecclog_pkg::SYN_W-1:0] syndrome,
  input wire logic singleLogEn,
  ecclog_err_if.src ev
);
  // Combinational qualify; single errors pass only while logging enabled
  always_comb begin
    ev.dbl = readCycle && doubleErr;
    ev.single = readCycle && singleErr && !doubleErr && singleLogEn;
    ev.hit = ev.dbl || ev.single;
    ev.syn = syndrome;
  end
  a_single_gated: assert property (@(posedge clk) disable iff (!resetn)
    ev.hit |-> (doubleErr || singleLogEn)) else $error("single logged while disabled");
endmodule

// *** hw/ecclog_pkg.sv ***
// Summary of operation
// - Wrong-checkword bit inverts two check bits on writes
// - Parity-error line asserted with data on qualifying errors
// - Unused register bits read as zero
// - Extended view mirrors bits 15,14,2,0, which writes in that view still update
// - Error captures A21-A18 into extended bits 8-5
// - Low byte write selects status register for one access
// - Status bit 13 suppresses read stretch on double error
// - Status bit 12 enables logging single errors too
// - Single-error logging bit self-clears on first error
// - Status bits 11-9 hold failing row number
// - Status bits 8-3 hold syndrome of failing chip
// - Double flag set on double error, cleared by single
// - Status bits 15,14,2,0 mirror control bits
// - Control word write with bit 14 selects extended view
// - After selected access, shared address reverts to control, or to extended view if bit 14 is set
// - Control bit 15 set on logged read error
// - Control bits 11-5 capture A17-A11 on logged error
package ecclog_pkg;
  localparam int DATA_W = 16;
  localparam int ERR_BIT = 15;
  localparam int RETR_BIT = 14;
  localparam int SHORT_BIT = 13;
  localparam int SINGLE_BIT = 12;
  localparam int ROW_HI = 11;
  localparam int ROW_LO = 9;
  localparam int ADR_HI = 11;
  localparam int ADR_LO = 5;
  localparam int XADR_HI = 8;
  localparam int XADR_LO = 5;
  localparam int SYN_HI = 8;
  localparam int SYN_LO = 3;
  localparam int WWC_BIT = 2;
  localparam int DBL_BIT = 1;
  localparam int IEN_BIT = 0;
  localparam int ROW_W = 3;
  localparam int SYN_W = 6;
  localparam int LADR_W = 7;
  localparam int UADR_W = 4;
  localparam int CHECK_W = 6;
  localparam logic [CHECK_W-1:0] WRONG_CHECK_MASK = 6'h03;
  localparam int STRETCH_NS = 50;
  localparam int CLK_MHZ = 200;
  localparam int STRETCH_CYC = (STRETCH_NS * CLK_MHZ + 999) / 1000;
  typedef enum logic [1:0] {ECCLOG_VIEW_CTRL, ECCLOG_VIEW_EXT, ECCLOG_VIEW_STAT} ecclog_view_t;
endpackage

// *** hw/ecclog_regs.sv ***
`timescale 1ns/10ps
module ecclog_regs (
  input wire logic clk,
  input wire logic resetn,
  input wire logic busInit,
  input wire logic accStb,
  input wire logic accWrite,
  input wire logic accByte,
  input wire logic accHighByte,
  input wire logic accPause,
  input wire logic [ecclog_pkg::DATA_W-1:0] wrData,
  input wire logic [21:11] busAddr,
  input wire logic readCycle,
  input wire logic singleErr,
  input wire logic doubleErr,
  input wire logic [ecclog_pkg::SYN_W-1:0] syndrome,
  input wire logic [ecclog_pkg::ROW_W-1:0] rowNum,
  input wire logic dataStb,
  input wire logic memWrite,
  output logic [ecclog_pkg::DATA_W-1:0] rdData,
  output logic parityErr,
  output logic [ecclog_pkg::CHECK_W-1:0] checkFlip,
  output logic stretchRead
);
  // Countdown is eight bits wide; a longer stretch would wrap
  if (ecclog_pkg::STRETCH_CYC < 1 || ecclog_pkg::STRETCH_CYC > 255) begin : g_bad_stretch
    $error("stretch count does not fit its counter");
  end

  logic errR, retrR, wwcR, ienR, shortR, singleR, dblR;
  logic [ecclog_pkg::LADR_W-1:0] ladrR;
  logic [ecclog_pkg::UADR_W-1:0] uadrR;
  logic [ecclog_pkg::ROW_W-1:0] rowR;
  logic [ecclog_pkg::SYN_W-1:0] synR;
  ecclog_pkg::ecclog_view_t viewR;
  logic [ecclog_pkg::DATA_W-1:0] rdData_r, rdData_nxt;
  logic parityErr_r, stretch_r;
  logic [ecclog_pkg::CHECK_W-1:0] checkFlip_r;
  logic [7:0] stretchCnt;
  ecclog_pkg::ecclog_view_t rdView_r;
  ecclog_err_if ev();

  ecclog_err_qual u_qual (
    .clk(clk),
    .resetn(resetn),
    .readCycle(readCycle),
    .singleErr(singleErr),
    .doubleErr(doubleErr),
    .syndrome(syndrome),
    .singleLogEn(singleR),
    .ev(ev)
  );

  // Read-pause counts as a read even if the write strobe is set
  wire logic wrAcc = accStb && accWrite && !accPause;
  wire logic rdAcc = accStb && !wrAcc;
  wire logic ctrlWr = wrAcc && (viewR != ecclog_pkg::ECCLOG_VIEW_STAT);
  wire logic statWr = wrAcc && !accByte && (viewR == ecclog_pkg::ECCLOG_VIEW_STAT);
  wire logic selStat = ctrlWr && accByte && !accHighByte;

  function automatic logic [ecclog_pkg::DATA_W-1:0] mirror(input logic e, input logic r,
                                                          input logic w, input logic i);
    logic [ecclog_pkg::DATA_W-1:0] m;
    m = '0;
    m[ecclog_pkg::ERR_BIT] = e;
    m[ecclog_pkg::RETR_BIT] = r;
    m[ecclog_pkg::WWC_BIT] = w;
    m[ecclog_pkg::IEN_BIT] = i;
    return m;
  endfunction

  // View selection; status view lasts exactly one following access
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      viewR <= ecclog_pkg::ECCLOG_VIEW_CTRL;
    end else if (busInit) begin
      viewR <= ecclog_pkg::ECCLOG_VIEW_CTRL;
    end else if (accStb) begin
      if (selStat) begin
        viewR <= ecclog_pkg::ECCLOG_VIEW_STAT;
      end else if (viewR == ecclog_pkg::ECCLOG_VIEW_STAT) begin
        viewR <= retrR ? ecclog_pkg::ECCLOG_VIEW_EXT : ecclog_pkg::ECCLOG_VIEW_CTRL;
      end else if (ctrlWr && !accByte) begin
        viewR <= wrData[ecclog_pkg::RETR_BIT] ? ecclog_pkg::ECCLOG_VIEW_EXT
                                              : ecclog_pkg::ECCLOG_VIEW_CTRL;
      end
    end
  end

  // Control bits; event set beats a software clear
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      errR <= 1'b0;
      retrR <= 1'b0;
      wwcR <= 1'b0;
      ienR <= 1'b0;
      ladrR <= '0;
    end else if (busInit) begin
      errR <= 1'b0;
      retrR <= 1'b0;
      wwcR <= 1'b0;
      ienR <= 1'b0;
    end else begin
      if (ctrlWr && !accHighByte) begin
        ienR <= wrData[ecclog_pkg::IEN_BIT];
        wwcR <= wrData[ecclog_pkg::WWC_BIT];
        ladrR[2:0] <= wrData[7:ecclog_pkg::ADR_LO];
      end
      if (ctrlWr && (!accByte || accHighByte)) begin
        errR <= wrData[ecclog_pkg::ERR_BIT];
        retrR <= wrData[ecclog_pkg::RETR_BIT];
        ladrR[6:3] <= wrData[ecclog_pkg::ADR_HI:8];
      end
      if (ev.hit) begin
        errR <= 1'b1;
        ladrR <= busAddr[17:11];
      end
    end
  end

  // Upper address always captured regardless of retrieval bit
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      uadrR <= '0;
    end else if (ev.hit) begin
      uadrR <= busAddr[21:18];
    end
  end

  // Status register fields
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      shortR <= 1'b0;
      singleR <= 1'b0;
      dblR <= 1'b0;
      rowR <= '0;
      synR <= '0;
    end else if (busInit) begin
      shortR <= 1'b0;
      singleR <= 1'b0;
      dblR <= 1'b0;
    end else begin
      if (statWr) begin
        shortR <= wrData[ecclog_pkg::SHORT_BIT];
        singleR <= wrData[ecclog_pkg::SINGLE_BIT];
      end
      if (ev.hit || (readCycle && singleErr && singleR)) begin
        singleR <= 1'b0;
      end
      if (ev.hit) begin
        rowR <= rowNum;
        synR <= ev.syn;
      end
      if (ev.dbl) begin
        dblR <= 1'b1;
      end else if (ev.single) begin
        dblR <= 1'b0;
      end
    end
  end

  // Read mux; reserved positions stay zero
  always_comb begin
    rdData_nxt = mirror(errR, retrR, wwcR, ienR);
    case (viewR)
      ecclog_pkg::ECCLOG_VIEW_CTRL: begin
        rdData_nxt[ecclog_pkg::ADR_HI:ecclog_pkg::ADR_LO] = ladrR;
      end
      ecclog_pkg::ECCLOG_VIEW_EXT: begin
        rdData_nxt[ecclog_pkg::XADR_HI:ecclog_pkg::XADR_LO] = uadrR;
      end
      ecclog_pkg::ECCLOG_VIEW_STAT: begin
        rdData_nxt[ecclog_pkg::SHORT_BIT] = shortR;
        rdData_nxt[ecclog_pkg::SINGLE_BIT] = singleR;
        rdData_nxt[ecclog_pkg::ROW_HI:ecclog_pkg::ROW_LO] = rowR;
        rdData_nxt[ecclog_pkg::SYN_HI:ecclog_pkg::SYN_LO] = synR;
        rdData_nxt[ecclog_pkg::DBL_BIT] = dblR;
      end
      default: begin
        rdData_nxt = '0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdData_r <= '0;
    end else if (rdAcc) begin
      rdData_r <= rdData_nxt;
    end
  end

  // View of the last read, so reserved-bit checks follow the data
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdView_r <= ecclog_pkg::ECCLOG_VIEW_CTRL;
    end else if (rdAcc) begin
      rdView_r <= viewR;
    end
  end

  // Parity-error flag uses pre-event error and double state
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      parityErr_r <= 1'b0;
    end else if (dataStb) begin
      parityErr_r <= ienR && readCycle && (doubleErr
                     || (singleErr && dblR && !errR));
    end else begin
      parityErr_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      checkFlip_r <= '0;
    end else begin
      checkFlip_r <= (memWrite && wwcR) ? ecclog_pkg::WRONG_CHECK_MASK : '0;
    end
  end

  // Stretch is a fixed window after a double error unless short cycle set
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      stretchCnt <= '0;
      stretch_r <= 1'b0;
    end else if (ev.dbl && !shortR) begin
      stretchCnt <= 8'(ecclog_pkg::STRETCH_CYC);
      stretch_r <= 1'b1;
    end else if (stretchCnt > 8'h01) begin
      stretchCnt <= stretchCnt - 8'h01;
    end else begin
      stretchCnt <= '0;
      stretch_r <= 1'b0;
    end
  end

  assign rdData = rdData_r;
  assign parityErr = parityErr_r;
  assign checkFlip = checkFlip_r;
  assign stretchRead = stretch_r;

  sequence s_sel_stat;
    accStb && selStat && !busInit;
  endsequence
  sequence s_stat_acc;
    accStb && viewR == ecclog_pkg::ECCLOG_VIEW_STAT && !busInit;
  endsequence
  sequence s_dbl_hit;
    ev.dbl && !shortR;
  endsequence

  // Status view is one access wide, whatever that access is
  a_stat_one_access: assert property (@(posedge clk) disable iff (!resetn)
    s_stat_acc |=> viewR != ecclog_pkg::ECCLOG_VIEW_STAT)
    else $error("status view persisted");
  a_stat_selected: assert property (@(posedge clk) disable iff (!resetn)
    s_sel_stat |=> viewR == ecclog_pkg::ECCLOG_VIEW_STAT)
    else $error("status not selected");
  a_ext_select: assert property (@(posedge clk) disable iff (!resetn)
    (ctrlWr && !accByte && !busInit && wrData[ecclog_pkg::RETR_BIT])
      |=> viewR == ecclog_pkg::ECCLOG_VIEW_EXT)
    else $error("extended view missed");
  a_err_sets: assert property (@(posedge clk) disable iff (!resetn)
    (ev.hit && !busInit) |=> errR && ladrR == $past(busAddr[17:11]))
    else $error("error not logged");
  a_upper_addr: assert property (@(posedge clk) disable iff (!resetn)
    (ev.hit && !busInit) |=> uadrR == $past(busAddr[21:18]))
    else $error("upper address lost");
  a_row_syn: assert property (@(posedge clk) disable iff (!resetn)
    (ev.hit && !busInit) |=> rowR == $past(rowNum) && synR == $past(syndrome))
    else $error("row or syndrome lost");
  a_dbl_flag: assert property (@(posedge clk) disable iff (!resetn)
    (ev.dbl && !busInit) |=> dblR && !singleR)
    else $error("double flag not set");
  a_single_clear: assert property (@(posedge clk) disable iff (!resetn)
    (ev.single && !busInit) |=> !dblR && !singleR)
    else $error("single log not cleared");
  a_init_clear: assert property (@(posedge clk) disable iff (!resetn)
    busInit |=> !errR && !retrR && !wwcR && !ienR && !shortR && !singleR && !dblR
      && viewR == ecclog_pkg::ECCLOG_VIEW_CTRL)
    else $error("bus init left state set");
  a_wrong_check: assert property (@(posedge clk) disable iff (!resetn)
    (memWrite && wwcR) |=> checkFlip == ecclog_pkg::WRONG_CHECK_MASK)
    else $error("check not flipped");
  a_parity_err: assert property (@(posedge clk) disable iff (!resetn)
    (dataStb && ienR && readCycle && doubleErr) |=> parityErr)
    else $error("parity error missed");
  a_parity_idle: assert property (@(posedge clk) disable iff (!resetn)
    !dataStb |=> !parityErr)
    else $error("parity error without data");
  a_stretch_start: assert property (@(posedge clk) disable iff (!resetn)
    s_dbl_hit |=> stretchRead && stretchCnt == 8'(ecclog_pkg::STRETCH_CYC))
    else $error("stretch not started");
  a_no_stretch: assert property (@(posedge clk) disable iff (!resetn)
    (ev.dbl && shortR && !stretchRead) |=> !stretchRead)
    else $error("stretched in short mode");
  a_ext_mirror: assert property (@(posedge clk) disable iff (!resetn)
    (rdAcc && viewR == ecclog_pkg::ECCLOG_VIEW_EXT)
      |=> {rdData[15:14], rdData[2], rdData[0]}
        == {$past(errR), $past(retrR), $past(wwcR), $past(ienR)})
    else $error("extended mirror wrong");
  a_stat_mirror: assert property (@(posedge clk) disable iff (!resetn)
    (rdAcc && viewR == ecclog_pkg::ECCLOG_VIEW_STAT)
      |=> {rdData[15:14], rdData[2], rdData[0]}
        == {$past(errR), $past(retrR), $past(wwcR), $past(ienR)})
    else $error("status mirror wrong");
  // Judged by the view the data was read in, not the current one
  a_zero_bits: assert property (@(posedge clk) disable iff (!resetn)
    (rdView_r != ecclog_pkg::ECCLOG_VIEW_STAT)
      |-> rdData[13:12] == 2'h0 && rdData[4:3] == 2'h0 && rdData[1] == 1'b0)
    else $error("reserved bit set");
  a_zero_ext: assert property (@(posedge clk) disable iff (!resetn)
    (rdView_r == ecclog_pkg::ECCLOG_VIEW_EXT) |-> rdData[11:9] == 3'h0)
    else $error("extended reserved bit set");
endmodule

// *** verif/ecclog_host.sv ***
`timescale 1ns/10ps
module ecclog_host (
  input wire logic clk,
  input wire logic [15:0] rdData,
  output logic accStb,
  output logic accWrite,
  output logic accByte,
  output logic accHighByte,
  output logic accPause,
  output logic [15:0] wrData
);
  initial begin
    {accStb, accWrite, accByte, accHighByte, accPause} = 5'h00;
    wrData = 16'h0000;
  end

  // Qualifiers held up to the taking edge; released data lines go stale-inverted
  task automatic acc(input logic w, input logic b, input logic p, input logic [15:0] d,
      output logic [15:0] q);
    @(posedge clk);
    #1;
    {accStb, accWrite, accByte, accPause} = {1'h1, w, b, p};
    wrData = d;
    @(posedge clk);
    #1;
    accStb = 1'h0;
    wrData = ~d;
    q = rdData;
  endtask

  task automatic wr(input logic [15:0] d);
    logic [15:0] t;
    acc(1'h1, 1'h0, 1'h0, d, t);
  endtask

  task automatic rd(output logic [15:0] q);
    acc(1'h0, 1'h0, 1'h0, wrData, q);
  endtask

  // Upper failing address only shows after bit 14 is written
  task automatic rdExt(input logic [15:0] d, output logic [15:0] q);
    wr(d);
    rd(q);
  endtask

  // Status reached by the one access right after the low-byte select, here a paused word read
  task automatic rdStat(input logic [7:0] lb, output logic [15:0] q);
    logic [15:0] t;
    acc(1'h1, 1'h1, 1'h0, {8'h00, lb}, t);
    acc(1'h0, 1'h0, 1'h1, wrData, q);
  endtask

  task automatic wrStat(input logic [7:0] lb, input logic [15:0] d);
    logic [15:0] t;
    acc(1'h1, 1'h1, 1'h0, {8'h00, lb}, t);
    acc(1'h1, 1'h0, 1'h0, d, t);
  endtask

  // High lane only; lane select settles before the strobe edge
  task automatic wrHigh(input logic [15:0] d);
    logic [15:0] t;
    accHighByte = 1'h1;
    acc(1'h1, 1'h1, 1'h0, d, t);
    accHighByte = 1'h0;
  endtask
endmodule

// *** verif/ecclog_regs_tb.sv ***
`timescale 1ns/10ps
module ecclog_regs_tb;
  typedef struct {logic [15:0] d; logic [15:0] e;} ecclog_row_t;
  logic clk = 1'h0;
  logic resetn = 1'h0;
  logic busInit = 1'h0;
  logic accStb, accWrite, accByte, accHighByte, accPause, parityErr, stretchRead, s;
  logic [15:0] wrData, rdData, v;
  logic [21:11] busAddr = 11'h000;
  logic readCycle = 1'h0, singleErr = 1'h0, doubleErr = 1'h0, dataStb = 1'h0, memWrite = 1'h0;
  logic [5:0] syndrome = 6'h00;
  logic [5:0] checkFlip;
  logic [2:0] rowNum = 3'h0;
  int numErrors = 0;
  int nTests = 0;
  ecclog_row_t rows [5] = '{'{16'h0005, 16'h0005}, '{16'h301a, 16'h0000},
    '{16'h0004, 16'h0004}, '{16'h4005, 16'h4005}, '{16'h0000, 16'h0000}};

  always #2.5 clk = ~clk;

  ecclog_regs ecclog_regs_inst (.clk(clk), .resetn(resetn), .busInit(busInit),
    .accStb(accStb), .accWrite(accWrite), .accByte(accByte), .accHighByte(accHighByte),
    .accPause(accPause), .wrData(wrData), .busAddr(busAddr), .readCycle(readCycle),
    .singleErr(singleErr), .doubleErr(doubleErr), .syndrome(syndrome), .rowNum(rowNum),
    .dataStb(dataStb), .memWrite(memWrite), .rdData(rdData), .parityErr(parityErr),
    .checkFlip(checkFlip), .stretchRead(stretchRead));

  ecclog_host ecclog_host_inst (.clk(clk), .rdData(rdData), .accStb(accStb),
    .accWrite(accWrite), .accByte(accByte), .accHighByte(accHighByte),
    .accPause(accPause), .wrData(wrData));

  task automatic chk(input logic [15:0] sv, input logic [15:0] e);
    nTests++;
    if (sv !== e) begin
      numErrors++;
      $display("mismatch at %0t: seen %h expected %h", $time, sv, e);
    end
  endtask

  task automatic wrapUp;
    $display("comparisons %0d mismatches %0d", nTests, numErrors);
    if (numErrors == 0 && nTests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // Flags order: readCycle, singleErr, doubleErr, dataStb, memWrite
  task automatic mem(input logic [4:0] f);
    @(posedge clk);
    #1;
    {readCycle, singleErr, doubleErr, dataStb, memWrite} = f;
    @(posedge clk);
    #1;
    {readCycle, singleErr, doubleErr, dataStb, memWrite} = 5'h00;
  endtask

  // Window, not an exact edge: onset and length of the stretch are design choices
  task automatic stretchSeen(output logic o);
    o = 1'h0;
    repeat (ecclog_pkg::STRETCH_CYC + 2) begin
      o = o | stretchRead;
      @(posedge clk);
      #1;
    end
  endtask

  initial begin
    repeat (4) @(posedge clk);
    #1;
    resetn = 1'h1;
    ecclog_host_inst.rd(v);
    chk(v, 16'h0000);
    foreach (rows[i]) begin
      ecclog_host_inst.wr(rows[i].d);
      ecclog_host_inst.rd(v);
      chk(v, rows[i].e);
    end
    ecclog_host_inst.wr(16'h0001);
    busAddr = 11'h566;
    rowNum = 3'h5;
    syndrome = 6'h2b;
    mem(5'h16);
    chk(16'(parityErr), 16'h0001);
    stretchSeen(s);
    chk(16'(s), 16'h0001);
    ecclog_host_inst.rd(v);
    chk(v, 16'h8cc1);
    ecclog_host_inst.rdExt(16'hccc1, v);
    chk(v, 16'hc141);
    ecclog_host_inst.rdStat(8'hc1, v);
    chk(v & 16'hfe07, 16'hca03);
    ecclog_host_inst.rd(v);
    chk(v, 16'hc141);
    ecclog_host_inst.wrStat(8'hc1, 16'h3000);
    ecclog_host_inst.rdStat(8'hc1, v);
    chk(v & 16'hfe07, 16'hfa03);
    rowNum = 3'h2;
    mem(5'h1a);
    chk(16'(parityErr), 16'h0000);
    ecclog_host_inst.rdStat(8'hc1, v);
    chk(v, 16'he559);
    mem(5'h16);
    chk(16'(parityErr), 16'h0001);
    stretchSeen(s);
    chk(16'(s), 16'h0000);
    ecclog_host_inst.wr(16'h0004);
    mem(5'h01);
    chk(16'(checkFlip), 16'h0003);
    ecclog_host_inst.wr(16'h0000);
    mem(5'h01);
    chk(16'(checkFlip), 16'h0000);
    ecclog_host_inst.wr(16'h4005);
    @(posedge clk);
    #1;
    busInit = 1'h1;
    @(posedge clk);
    #1;
    busInit = 1'h0;
    ecclog_host_inst.rd(v);
    chk(v, 16'h0000);
    ecclog_host_inst.wrHigh(16'h8c00);
    ecclog_host_inst.rd(v);
    chk(v, 16'h8c00);
    resetn = 1'h0;
    @(posedge clk);
    #1;
    resetn = 1'h1;
    ecclog_host_inst.rd(v);
    chk(v, 16'h0000);
    wrapUp();
  end

  // Whole sequence needs about a hundred cycles
  initial begin
    #20000;
    numErrors++;
    wrapUp();
  end
endmodule
